//--- hw/pwmps_cfg.svh
// register offsets, field positions, masks and reset values of the
// pwm period source and auto-shutdown slice; assumes an 8-bit byte address
`ifndef PWMPS_CFG_SVH
`define PWMPS_CFG_SVH
// register byte offsets
`define PWMPS_OFS_PRS 8'h00
`define PWMPS_OFS_ASDC 8'h04
`define PWMPS_OFS_ASDL 8'h08
`define PWMPS_OFS_ASDS 8'h0C
`define PWMPS_OFS_PER 8'h10
`define PWMPS_OFS_IST 8'h14
`define PWMPS_OFS_IMSK 8'h18
`define PWMPS_OFS_TB 8'h1C
// implemented bits of each 8-bit register
`define PWMPS_PRS_MASK 8'h9F
`define PWMPS_ASDC_MASK 8'hE1
`define PWMPS_ASDL_MASK 8'h3F
`define PWMPS_ASDL_AB_MASK 8'h03
`define PWMPS_ASDS_MASK 8'h9E
`define PWMPS_IRQ_MASK 8'h03
// field positions
`define PWMPS_BIT_PIN 7
`define PWMPS_BIT_TBM 0
`define PWMPS_BIT_ASE 7
`define PWMPS_BIT_ASDEN 6
`define PWMPS_BIT_ARSEN 5
`define PWMPS_BIT_ASDOV 0
`define PWMPS_IRQ_SHUT 0
`define PWMPS_IRQ_PER 1
// reset values
`define PWMPS_RST_REG 8'h00
`define PWMPS_RST_PER 16'h0000
// bus responses
`define PWMPS_RESP_OKAY 2'h0
`define PWMPS_RESP_SLVERR 2'h2
`endif

//--- hw/pwmps_pkg.sv
// types shared by the period source and auto-shutdown slice
// assumes nothing beyond a SystemVerilog compiler
package pwmps_pkg;
    // event sources: pin and four comparators, comparator 1 in bit 0
    typedef struct packed {
        logic pin;
        logic [3:0] cmp;
    } pwmps_src_t;
    // six pwm output lanes, a in the lowest bit
    typedef struct packed {
        logic f;
        logic e;
        logic d;
        logic c;
        logic b;
        logic a;
    } pwmps_out_t;
    // one register write taken from the bus
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pwmps_wreq_t;
endpackage

//--- hw/pwmps_sync.sv
// two-stage synchroniser for asynchronous levels with rising-edge detect
// assumes inputs are slow against aclk (at least two cycles per level)
`timescale 1ns/1ps
`default_nettype none
module pwmps_sync #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // raw levels and synchronised results
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] q_d;

    // first stage is read only by the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
            q_d <= '0;
        end else begin
            meta <= d;
            q <= meta;
            q_d <= q;
        end
    end

    // edge from the settled stage only
    assign rise = q & ~q_d;
endmodule
`default_nettype wire

//--- hw/pwmps_axil.sv
// axi4-lite slave front end: one write and one read in flight
// assumes the register file decodes rd_addr combinationally
`timescale 1ns/1ps
`default_nettype none
module pwmps_axil (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register file side
    output logic wr_fire,
    output pwmps_pkg::pwmps_wreq_t wr_req,
    input wire logic wr_ok,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
`include "pwmps_cfg.svh"
    // both halves held and no response pending
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_addr = s_axi_araddr;

    // address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_req <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_req.addr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_req.data <= s_axi_wdata;
                wr_req.strb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response raised on the same edge that the write lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PWMPS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PWMPS_RESP_OKAY : `PWMPS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read answered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PWMPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? `PWMPS_RESP_OKAY : `PWMPS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- hw/pwmps_top.sv
// pwm period event selection, time base and auto-shutdown control
// assumes raw pwm lanes come from duty logic on aclk; pin and
// comparator levels are asynchronous and are synchronised here
//
// Overview of operation
// - pin rising makes period event when selected
// - selected comparator rising makes period event
// - time base equal period makes period event
// - all enabled period sources are ORed
// - unimplemented register bits read zero
// - status bit shows outputs held in shutdown
// - enabled source forces shutdown, sets flag
// - auto-restart clears shutdown when condition goes
// - override with shutdown enabled forces levels without setting flag
// - no override: normal pwm and shutdown
// - software setting status equals hardware shutdown
// - each output drives its level in shutdown
// - second instance keeps only levels a, b
// - source select picks shutdown pin or comparators
`timescale 1ns/1ps
`default_nettype none
module pwmps_top #(
    parameter bit HAS_CDEF = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // asynchronous event sources
    input wire logic external_event_input,
    input wire logic [3:0] comparator_out,
    // raw pwm lanes from duty logic
    input wire pwmps_pkg::pwmps_out_t pwm_raw,
    // pwm pins
    output logic pwm_output_a,
    output logic pwm_output_b,
    output logic pwm_output_c,
    output logic pwm_output_d,
    output logic pwm_output_e,
    output logic pwm_output_f,
    // time base and status
    output logic period_event,
    output logic [15:0] time_base_counter,
    output logic shutdown_status,
    output logic irq
);
`include "pwmps_cfg.svh"
    // ************************************************
    // registers and wiring
    // ************************************************
    logic [7:0] prs;
    logic [7:0] asdc_cfg;
    logic [7:0] asdl;
    logic [7:0] asds;
    logic [15:0] period_value;
    logic [7:0] int_status;
    logic [7:0] int_mask;
    logic wr_fire;
    pwmps_pkg::pwmps_wreq_t wr_req;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [4:0] sync_q;
    logic [4:0] sync_rise;
    pwmps_pkg::pwmps_src_t src_lvl;
    pwmps_pkg::pwmps_src_t src_rise;
    pwmps_pkg::pwmps_out_t pwm_q;
    pwmps_pkg::pwmps_out_t level;
    logic tb_match;
    logic next_period_event;
    logic shutdown_enable;
    logic auto_restart_enable;
    logic shutdown_override;
    logic shut_cond;
    logic shut_cond_d;
    logic override_force;
    logic force_levels;
    logic sw_asdc;
    logic [7:0] asdl_mask;

    // merge byte 0 of a write into an 8-bit register
    function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                           input logic [7:0] mask);
        if (wr_req.strb[0]) begin
            wr_byte = wr_req.data[7:0] & mask;
        end else begin
            wr_byte = old;
        end
    endfunction

    // a bus write to the given offset in this cycle
    function automatic logic hit(input logic [7:0] ofs);
        hit = wr_fire && (wr_req.addr == ofs);
    endfunction

    // ************************************************
    // bus front end and synchronisers
    // ************************************************
    pwmps_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_fire(wr_fire),
        .wr_req(wr_req),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    pwmps_sync #(.W(5)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({external_event_input, comparator_out}),
        .q(sync_q),
        .rise(sync_rise)
    );
    assign src_lvl = sync_q;
    assign src_rise = sync_rise;

    // ************************************************
    // register file
    // ************************************************
    // second instance drops levels c to f
    assign asdl_mask = HAS_CDEF ? `PWMPS_ASDL_MASK : `PWMPS_ASDL_AB_MASK;
    assign sw_asdc = hit(`PWMPS_OFS_ASDC) && wr_req.strb[0];

    // configuration writes, unimplemented bits dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prs <= `PWMPS_RST_REG;
            asdc_cfg <= `PWMPS_RST_REG;
            asdl <= `PWMPS_RST_REG;
            asds <= `PWMPS_RST_REG;
            int_mask <= `PWMPS_RST_REG;
        end else begin
            if (hit(`PWMPS_OFS_PRS)) begin
                prs <= wr_byte(prs, `PWMPS_PRS_MASK);
            end
            if (hit(`PWMPS_OFS_ASDC)) begin
                // status bit lives in its own flop
                asdc_cfg <= wr_byte(asdc_cfg, `PWMPS_ASDC_MASK & 8'h7F);
            end
            if (hit(`PWMPS_OFS_ASDL)) begin
                asdl <= wr_byte(asdl, asdl_mask);
            end
            if (hit(`PWMPS_OFS_ASDS)) begin
                asds <= wr_byte(asds, `PWMPS_ASDS_MASK);
            end
            if (hit(`PWMPS_OFS_IMSK)) begin
                int_mask <= wr_byte(int_mask, `PWMPS_IRQ_MASK);
            end
        end
    end

    // 16-bit period value, two byte lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_value <= `PWMPS_RST_PER;
        end else if (hit(`PWMPS_OFS_PER)) begin
            if (wr_req.strb[0]) begin
                period_value[7:0] <= wr_req.data[7:0];
            end
            if (wr_req.strb[1]) begin
                period_value[15:8] <= wr_req.data[15:8];
            end
        end
    end

    // write accepted only at a mapped offset
    always_comb begin
        case (wr_req.addr)
            `PWMPS_OFS_PRS, `PWMPS_OFS_ASDC, `PWMPS_OFS_ASDL,
            `PWMPS_OFS_ASDS, `PWMPS_OFS_PER, `PWMPS_OFS_IST,
            `PWMPS_OFS_IMSK, `PWMPS_OFS_TB: begin
                wr_ok = 1'b1;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    end

    // read mux; unmapped offsets read zero with an error
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (rd_addr)
            `PWMPS_OFS_PRS: begin
                rd_data[7:0] = prs;
            end
            `PWMPS_OFS_ASDC: begin
                rd_data[7:0] = asdc_cfg;
                rd_data[`PWMPS_BIT_ASE] = shutdown_status;
            end
            `PWMPS_OFS_ASDL: begin
                rd_data[7:0] = asdl;
            end
            `PWMPS_OFS_ASDS: begin
                rd_data[7:0] = asds;
            end
            `PWMPS_OFS_PER: begin
                rd_data[15:0] = period_value;
            end
            `PWMPS_OFS_IST: begin
                rd_data[7:0] = int_status;
            end
            `PWMPS_OFS_IMSK: begin
                rd_data[7:0] = int_mask;
            end
            `PWMPS_OFS_TB: begin
                rd_data[15:0] = time_base_counter;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // ************************************************
    // period event and time base
    // ************************************************
    assign tb_match = (time_base_counter == period_value);
    // sources are not exclusive: any one fires the event
    assign next_period_event =
        (prs[`PWMPS_BIT_PIN] && src_rise.pin) ||
        (|(prs[4:1] & src_rise.cmp)) ||
        (prs[`PWMPS_BIT_TBM] && tb_match);

    // counter restarts on the event, otherwise wraps freely
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_base_counter <= 16'h0000;
            period_event <= 1'b0;
        end else begin
            period_event <= next_period_event;
            if (next_period_event) begin
                time_base_counter <= 16'h0000;
            end else begin
                time_base_counter <= time_base_counter + 16'h0001;
            end
        end
    end

    // ************************************************
    // auto-shutdown
    // ************************************************
    assign shutdown_enable = asdc_cfg[`PWMPS_BIT_ASDEN];
    assign auto_restart_enable = asdc_cfg[`PWMPS_BIT_ARSEN];
    assign shutdown_override = asdc_cfg[`PWMPS_BIT_ASDOV];
    // level sensitive: a held fault keeps re-asserting
    assign shut_cond = shutdown_enable &&
        ((asds[`PWMPS_BIT_PIN] && src_lvl.pin) ||
         (|(asds[4:1] & src_lvl.cmp)));
    assign override_force = shutdown_enable && shutdown_override;
    assign force_levels = shutdown_status || override_force;
    assign level = asdl[5:0];

    // status: hardware set beats any software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_status <= 1'b0;
            shut_cond_d <= 1'b0;
        end else begin
            shut_cond_d <= shut_cond;
            if (shut_cond) begin
                shutdown_status <= 1'b1;
            end else if (sw_asdc) begin
                // set acts like hardware, clear restarts
                shutdown_status <= wr_req.data[`PWMPS_BIT_ASE];
            end else if (auto_restart_enable && shut_cond_d) begin
                shutdown_status <= 1'b0;
            end
        end
    end

    // outputs: levels while shut down or overridden
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_q <= '0;
        end else if (force_levels) begin
            pwm_q <= level;
        end else begin
            pwm_q <= pwm_raw;
        end
    end
    assign pwm_output_a = pwm_q.a;
    assign pwm_output_b = pwm_q.b;
    assign pwm_output_c = pwm_q.c;
    assign pwm_output_d = pwm_q.d;
    assign pwm_output_e = pwm_q.e;
    assign pwm_output_f = pwm_q.f;

    // ************************************************
    // interrupts
    // ************************************************
    // sticky flags, write one to clear, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= `PWMPS_RST_REG;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (hit(`PWMPS_OFS_IST) && wr_req.strb[0] &&
                    wr_req.data[i]) begin
                    int_status[i] <= 1'b0;
                end
            end
            if (shut_cond && !shutdown_override) begin
                int_status[`PWMPS_IRQ_SHUT] <= 1'b1;
            end
            if (next_period_event) begin
                int_status[`PWMPS_IRQ_PER] <= 1'b1;
            end
            irq <= |(int_status & int_mask);
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_cond_gone;
        auto_restart_enable && shut_cond_d && !shut_cond && !sw_asdc;
    endsequence
    sequence s_sw_set;
        sw_asdc && wr_req.data[`PWMPS_BIT_ASE];
    endsequence

    AST_PIN_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        prs[7] && src_rise.pin |=> period_event && time_base_counter == 16'h0000)
        else $error("pin period event missing");
    AST_CMP_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        |(prs[4:1] & src_rise.cmp) |=> period_event)
        else $error("comparator period event missing");
    AST_MATCH_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
        prs[0] && tb_match |=> time_base_counter == 16'h0000)
        else $error("time base not reset on match");
    AST_NO_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
        period_event |-> $past(|({prs[7], prs[4:1]} &
        {src_rise.pin, src_rise.cmp})) || $past(prs[0] && tb_match))
        else $error("period event without a source");
    AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        (prs & 8'h60) == 8'h00 && (asdc_cfg & 8'h1E) == 8'h00 &&
        (asdl & 8'hC0) == 8'h00)
        else $error("unimplemented bit set");
    AST_SHUT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        shut_cond |=> shutdown_status ##1 pwm_q == $past(level))
        else $error("shutdown not entered");
    AST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
        s_cond_gone |=> !shutdown_status)
        else $error("auto-restart missing");
    AST_SW_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        s_sw_set |=> shutdown_status)
        else $error("software shutdown ignored");
    AST_OVERRIDE: assert property (@(posedge aclk) disable iff (!aresetn)
        override_force && !int_status[0] && !shut_cond_d |=>
        pwm_q == $past(level) && !int_status[0])
        else $error("override wrong");
    AST_NORMAL: assert property (@(posedge aclk) disable iff (!aresetn)
        !force_levels |=> pwm_q == $past(pwm_raw))
        else $error("normal pwm not passed");
    AST_NARROW: assert property (@(posedge aclk) disable iff (!aresetn)
        !HAS_CDEF |-> asdl[5:2] == 4'h0)
        else $error("levels c-f present");
    AST_IGNORE_OV: assert property (@(posedge aclk) disable iff (!aresetn)
        !shutdown_enable && !shutdown_status |=> pwm_q == $past(pwm_raw))
        else $error("override acted while disabled");
endmodule
`default_nettype wire

//--- sim/pwmps_src_model.sv
// model of the comparators and the external fault pin
// assumes the bench asks for levels; they move off the clock edge
`timescale 1ns/1ps
`default_nettype none
module pwmps_src_model (
    // clock
    input wire logic aclk,
    // levels asked for by the bench, pin in the top bit
    input wire pwmps_pkg::pwmps_src_t want,
    // levels seen by the block
    output logic external_event_input,
    output logic [3:0] comparator_out
);
    // quiet levels until the first edge
    initial begin
        external_event_input = 1'b0;
        comparator_out = 4'h0;
    end
    // 3 ns skew so levels land unrelated to the sampling edge
    always @(posedge aclk) begin
        external_event_input <= #3 want.pin;
        comparator_out <= #3 want.cmp;
    end
endmodule
`default_nettype wire

//--- sim/test_pwmps_top.sv
// bench for period source and auto-shutdown slice
// assumes axi4-lite access and the offsets of pwmps_cfg.svh
`timescale 1ns/1ps
`default_nettype none
`include "pwmps_cfg.svh"
module test_pwmps_top;
    logic aclk, aresetn, aw_v, w_v, b_r, ar_v, r_v;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_vld, period_event, shutdown_status;
    logic irq, pa, pb, pc, pd, pe, pf;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] tbc;
    pwmps_pkg::pwmps_src_t want;
    pwmps_pkg::pwmps_out_t raw;
    logic ev;
    int fails, compares, cyc;
    wire logic src_pin;
    wire logic [3:0] src_cmp;
    // *****************************************
    // instances and clock
    // *****************************************
    pwmps_top pwmps_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(r_vld), .s_axi_rready(r_v),
        .external_event_input(src_pin), .comparator_out(src_cmp),
        .pwm_raw(raw), .pwm_output_a(pa), .pwm_output_b(pb),
        .pwm_output_c(pc), .pwm_output_d(pd), .pwm_output_e(pe),
        .pwm_output_f(pf), .period_event(period_event),
        .time_base_counter(tbc), .shutdown_status(shutdown_status),
        .irq(irq));
    pwmps_src_model pwmps_src_model_i (.aclk(aclk), .want(want),
        .external_event_input(src_pin), .comparator_out(src_cmp));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // hang guard, well above the run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end
    // *****************************************
    // bus and compare tasks
    // *****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
        fork
            begin do @(posedge aclk); while (aw_rdy !== 1'b1); aw_v <= 1'b0; end
            begin do @(posedge aclk); while (w_rdy !== 1'b1); w_v <= 1'b0; end
        join
        while (b_v !== 1'b1) @(posedge aclk);
        b_r <= 1'b0;
        rs = bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; ar_v <= 1'b1; r_v <= 1'b1;
        do @(posedge aclk); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        while (r_vld !== 1'b1) @(posedge aclk);
        r_v <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask
    // any period pulse within the window of sync plus detect delay
    task automatic see_ev(input pwmps_pkg::pwmps_src_t s);
        want <= s;
        ev = 1'b0;
        repeat (10) begin
            @(posedge aclk);
            if (period_event === 1'b1) ev = 1'b1;
        end
        want <= '0;
        repeat (6) @(posedge aclk);
    endtask
    task automatic finish_test();
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // *****************************************
    // scenarios
    // *****************************************
    wire logic [5:0] pins = {pf, pe, pd, pc, pb, pa};
    initial begin
        {aw_v, w_v, b_r, ar_v, r_v} = 5'h00;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
        wstrb = 4'hf; want = '0; raw = 6'h15; aresetn = 1'b0;
        fails = 0; compares = 0; cyc = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // unimplemented bits ignore writes, unmapped place refused
        wr(`PWMPS_OFS_PRS, 32'h0000_00FF); chk(rs, `PWMPS_RESP_OKAY);
        rdr(`PWMPS_OFS_PRS);
        chk(rd, 32'h0000_009F);
        wr(`PWMPS_OFS_ASDL, 32'h0000_00FF); rdr(`PWMPS_OFS_ASDL);
        chk(rd, 32'h0000_003F);
        wr(`PWMPS_OFS_ASDC, 32'h0000_001E); rdr(`PWMPS_OFS_ASDC);
        chk(rd, 32'h0000_0000);
        rdr(8'h20); chk(rs, `PWMPS_RESP_SLVERR); chk(rd, 32'h0000_0000);
        // each source off then on: pin bit 7, comparators bits 4..1
        for (int i = 0; i < 5; i++) begin
            wr(`PWMPS_OFS_PRS, 32'h0000_0000);
            see_ev(i == 0 ? 5'h10 : 5'h01 << (i - 1)); chk(ev, 1'b0);
            wr(`PWMPS_OFS_PRS, i == 0 ? 32'h0000_0080 : 32'h0000_0001 << i);
            see_ev(i == 0 ? 5'h10 : 5'h01 << (i - 1)); chk(ev, 1'b1);
        end
        // period 3: a comparator 1 event restarts the free-running counter
        // first, so the match need not wait for a full 16-bit wrap
        wr(`PWMPS_OFS_PER, 32'h0000_0003); wr(`PWMPS_OFS_PRS, 32'h0000_0003);
        see_ev(5'h01); chk(ev, 1'b1);
        while (period_event !== 1'b1) @(posedge aclk);
        chk(tbc, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        chk({period_event, tbc}, 17'h1_0000);
        wr(`PWMPS_OFS_PRS, 32'h0000_0000); wr(`PWMPS_OFS_IST, 32'h0000_0003);
        // pin shutdown, no auto-restart
        wr(`PWMPS_OFS_ASDS, 32'h0000_0080); wr(`PWMPS_OFS_ASDL, 32'h0000_002A);
        wr(`PWMPS_OFS_IMSK, 32'h0000_0001); wr(`PWMPS_OFS_ASDC, 32'h0000_0040);
        want <= 5'h10; repeat (8) @(posedge aclk);
        rdr(`PWMPS_OFS_ASDC); chk(rd, 32'h0000_00C0);
        chk({pins, irq, shutdown_status}, {6'h2A, 2'b11});
        want <= '0; repeat (8) @(posedge aclk);
        chk(shutdown_status, 1'b1);
        wr(`PWMPS_OFS_ASDC, 32'h0000_0040); wr(`PWMPS_OFS_IST, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk({pins, irq, shutdown_status}, {6'h15, 2'b00});
        // auto-restart
        wr(`PWMPS_OFS_ASDC, 32'h0000_0060);
        want <= 5'h10; repeat (8) @(posedge aclk);
        chk(shutdown_status, 1'b1);
        want <= '0; repeat (8) @(posedge aclk);
        chk({pins, shutdown_status}, {6'h15, 1'b0});
        // override, then override with shutdown disabled
        // a live source must still leave the flag clear under override
        wr(`PWMPS_OFS_IST, 32'h0000_0001); wr(`PWMPS_OFS_ASDC, 32'h0000_0041);
        want <= 5'h10; repeat (8) @(posedge aclk);
        rdr(`PWMPS_OFS_IST); chk({pins, rd[0]}, {6'h2A, 1'b0});
        want <= '0; repeat (8) @(posedge aclk);
        wr(`PWMPS_OFS_ASDC, 32'h0000_0001); repeat (3) @(posedge aclk);
        chk(pins, 6'h15);
        // software-set shutdown
        wr(`PWMPS_OFS_ASDC, 32'h0000_00C0); repeat (3) @(posedge aclk);
        chk({pins, shutdown_status}, {6'h2A, 1'b1});
        finish_test();
    end
endmodule
`default_nettype wire
